// ===== logic/eipn_ctrl.sv
// Maskable and software interrupt controller with edge select and nesting.
`timescale 1ns/1ps
`include "eipn_defs.svh"
module eipn_ctrl
    import eipn_pkg::*;
#(
    parameter int SRC_N = 16,
    parameter int IDX_W = $clog2(SRC_N)
)
(
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic [6:0]           external_request_i,
    input  wire logic [SRC_N-8:0]     int_req_i,
    input  wire logic [SRC_N-1:0]     pend_set_i,
    input  wire logic [SRC_N-1:0]     pend_clr_i,
    input  wire logic [SRC_N-1:0]     mask_bit_i,
    input  wire logic [SRC_N-1:0]     level_select_bit_i,
    input  wire logic                 sfr_wr_i,
    input  wire logic [15:0]          sfr_addr_i,
    input  wire logic [7:0]           sfr_wdata_i,
    input  wire logic                 instr_end_i,
    input  wire logic                 instr_hold_i,
    input  wire logic                 software_trap_i,
    input  wire logic                 return_from_interrupt_i,
    input  wire logic                 return_from_trap_i,
    input  wire logic                 pop_status_i,
    input  wire logic                 push_status_i,
    input  wire logic                 set_enable_i,
    input  wire logic                 clear_enable_i,
    input  wire logic                 status_wr_i,
    input  wire logic [7:0]           status_wdata_i,
    output logic [7:0]                sfr_rdata_o,
    output logic [7:0]                status_word_o,
    output logic [SRC_N-1:0]          pending_o,
    output logic                      ack_o,
    output logic [IDX_W-1:0]          ack_idx_o,
    output logic                      svc_busy_o,
    output logic                      push_status_instruction_o,
    output logic [7:0]                push_data_o,
    output logic                      push_pc_o,
    output logic                      vector_valid_o,
    output logic [15:0]               vector_addr_o
);
    logic                 rst_meta_reg;
    logic                 rst_sync_reg;
    logic                 rst_b;
    logic [6:0]           rise_sel_reg;
    logic [6:0]           fall_sel_reg;
    logic [6:0]           edge_ev;
    logic [SRC_N-1:0]     src_ev;
    logic [SRC_N-1:0]     pending_reg;
    logic [SRC_N-1:0]     pending_next;
    logic [SRC_N-1:0]     ack_clr;
    logic [SRC_N-1:0]     ackable;
    logic [SRC_N-1:0]     hi_cand;
    logic [SRC_N-1:0]     lo_cand;
    logic [7:0]           status_reg;
    logic                 ie;
    logic                 in_service_level_flag;
    logic                 hold;
    logic                 boundary_ok;
    logic                 take_trap;
    logic                 take_mask;
    logic [IDX_W-1:0]     grant_idx;
    logic                 grant_lvl;
    eipn_state_t          state_reg;
    logic [5:0]           wait_reg;
    logic                 trap_reg;
    logic                 lvl_reg;
    logic [IDX_W-1:0]     idx_reg;

    // Lowest index wins: it holds the highest fixed default priority.
    function automatic logic [IDX_W-1:0] pick_first(input logic [SRC_N-1:0] v);
        logic [IDX_W-1:0] r;
        r = '0;
        for (int i = SRC_N - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = IDX_W'(i);
            end
        end
        return r;
    endfunction

    // Reset is asserted at once and released through two flops.
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_b = rst_sync_reg;

    // Edge select registers.
    always_ff @(posedge ref_clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rise_sel_reg <= `EIPN_EDGE_RST;
            fall_sel_reg <= `EIPN_EDGE_RST;
        end
        else if (sfr_wr_i)
        begin
            if (sfr_addr_i == `EIPN_ADDR_RISE)
            begin
                rise_sel_reg <= sfr_wdata_i[6:0];
            end
            if (sfr_addr_i == `EIPN_ADDR_FALL)
            begin
                fall_sel_reg <= sfr_wdata_i[6:0];
            end
        end
    end

    // Read data; unmapped addresses return zero.
    always_ff @(posedge ref_clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sfr_rdata_o <= 8'h00;
        end
        else if (sfr_addr_i == `EIPN_ADDR_RISE)
        begin
            sfr_rdata_o <= {1'b0, rise_sel_reg};
        end
        else if (sfr_addr_i == `EIPN_ADDR_FALL)
        begin
            sfr_rdata_o <= {1'b0, fall_sel_reg};
        end
        else
        begin
            sfr_rdata_o <= 8'h00;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `EIPN_EXT_N; g++)
        begin : g_edge
            eipn_edge_det u_edge (
                .ref_clk_i (ref_clk_i),
                .rst_b_i   (rst_b),
                .pin_i     (external_request_i[g]),
                .rise_en_i (rise_sel_reg[g]),
                .fall_en_i (fall_sel_reg[g]),
                .event_o   (edge_ev[g])
            );
        end
    endgenerate

    assign src_ev = {int_req_i, edge_ev};

    // A set in the same cycle as a clear wins, so no request is lost.
    always_comb
    begin
        ack_clr = '0;
        if (take_mask)
        begin
            ack_clr[grant_idx] = 1'b1;
        end
        pending_next = (pending_reg & ~(pend_clr_i | ack_clr))
                     | src_ev | pend_set_i;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pending_reg <= '0;
        end
        else
        begin
            pending_reg <= pending_next;
        end
    end

    assign ie  = status_reg[`EIPN_PSW_IE];
    assign in_service_level_flag = status_reg[`EIPN_PSW_ISP];

    // Returns count as hold instructions, so one main instruction always
    // completes after a return before another grant can happen.
    assign hold = instr_hold_i | return_from_interrupt_i | return_from_trap_i
                | pop_status_i | push_status_i | set_enable_i
                | clear_enable_i | status_wr_i;
    assign boundary_ok = instr_end_i & ~hold;

    // Requests blocked here simply stay pending and are retried each boundary.
    always_comb
    begin
        ackable = pending_reg & ~mask_bit_i;
        hi_cand = ackable & ~level_select_bit_i & {SRC_N{ie}};
        lo_cand = ackable & level_select_bit_i & {SRC_N{ie & in_service_level_flag}};
        if (|hi_cand)
        begin
            grant_idx = pick_first(hi_cand);
            grant_lvl = 1'b0;
        end
        else
        begin
            grant_idx = pick_first(lo_cand);
            grant_lvl = 1'b1;
        end
    end

    // The trap is not a hold instruction and needs neither enable nor level.
    assign take_trap = state_reg == EIPN_IDLE && instr_end_i && software_trap_i;
    assign take_mask = state_reg == EIPN_IDLE && boundary_ok && !software_trap_i
                     && (|(hi_cand | lo_cand));

    // Entry sequence. The wait stage pads the entry so the vector is loaded
    // a fixed number of clocks after the grant; the core adds its own
    // instruction time on top, which sets the worst case.
    always_ff @(posedge ref_clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg      <= EIPN_IDLE;
            wait_reg       <= 6'd0;
            trap_reg       <= 1'b0;
            lvl_reg        <= 1'b0;
            idx_reg        <= '0;
            ack_o          <= 1'b0;
            ack_idx_o      <= '0;
            svc_busy_o     <= 1'b0;
            push_status_instruction_o     <= 1'b0;
            push_pc_o      <= 1'b0;
            vector_valid_o <= 1'b0;
            vector_addr_o  <= 16'h0000;
        end
        else
        begin
            ack_o          <= 1'b0;
            push_status_instruction_o     <= 1'b0;
            push_pc_o      <= 1'b0;
            vector_valid_o <= 1'b0;
            case (state_reg)
                EIPN_IDLE:
                begin
                    if (take_trap)
                    begin
                        state_reg  <= EIPN_WAIT;
                        trap_reg   <= 1'b1;
                        lvl_reg    <= 1'b0;
                        svc_busy_o <= 1'b1;
                        wait_reg   <= `EIPN_LAT_MIN_HI - `EIPN_ENTRY_FIXED - 6'd1;
                    end
                    else if (take_mask)
                    begin
                        state_reg  <= EIPN_WAIT;
                        trap_reg   <= 1'b0;
                        lvl_reg    <= grant_lvl;
                        idx_reg    <= grant_idx;
                        ack_o      <= 1'b1;
                        ack_idx_o  <= grant_idx;
                        svc_busy_o <= 1'b1;
                        if (grant_lvl)
                        begin
                            wait_reg <= `EIPN_LAT_MIN_LO - `EIPN_ENTRY_FIXED - 6'd1;
                        end
                        else
                        begin
                            wait_reg <= `EIPN_LAT_MIN_HI - `EIPN_ENTRY_FIXED - 6'd1;
                        end
                    end
                end
                EIPN_WAIT:
                begin
                    if (wait_reg == 6'd0)
                    begin
                        state_reg  <= EIPN_PSW;
                        push_status_instruction_o <= 1'b1;
                    end
                    else
                    begin
                        wait_reg <= wait_reg - 6'd1;
                    end
                end
                EIPN_PSW:
                begin
                    state_reg <= EIPN_PC;
                    push_pc_o <= 1'b1;
                end
                EIPN_PC:
                begin
                    state_reg      <= EIPN_VEC;
                    vector_valid_o <= 1'b1;
                    if (trap_reg)
                    begin
                        vector_addr_o <= `EIPN_VEC_TRAP;
                    end
                    else
                    begin
                        vector_addr_o <= `EIPN_VEC_BASE
                                       + {{(15 - IDX_W){1'b0}}, idx_reg, 1'b0};
                    end
                end
                EIPN_VEC:
                begin
                    state_reg  <= EIPN_IDLE;
                    svc_busy_o <= 1'b0;
                end
                default:
                begin
                    state_reg  <= EIPN_IDLE;
                    svc_busy_o <= 1'b0;
                end
            endcase
        end
    end

    // Saved copy of the status word, captured before entry changes it.
    always_ff @(posedge ref_clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            push_data_o <= `EIPN_PSW_RST;
        end
        else if ((state_reg == EIPN_WAIT && wait_reg == 6'd0) || push_status_i)
        begin
            push_data_o <= status_reg;
        end
    end

    // Status word. Entry changes come first since the core is stalled then.
    always_ff @(posedge ref_clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            status_reg <= `EIPN_PSW_RST;
        end
        else if (state_reg == EIPN_PSW)
        begin
            status_reg[`EIPN_PSW_IE] <= 1'b0;
            if (!trap_reg)
            begin
                status_reg[`EIPN_PSW_ISP] <= lvl_reg;
            end
        end
        else if (return_from_interrupt_i || return_from_trap_i || pop_status_i)
        begin
            status_reg <= status_wdata_i;
        end
        else if (status_wr_i)
        begin
            status_reg <= status_wdata_i;
        end
        else if (set_enable_i)
        begin
            status_reg[`EIPN_PSW_IE] <= 1'b1;
        end
        else if (clear_enable_i)
        begin
            status_reg[`EIPN_PSW_IE] <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            status_word_o <= `EIPN_PSW_RST;
            pending_o     <= '0;
        end
        else
        begin
            status_word_o <= status_reg;
            pending_o     <= pending_reg;
        end
    end
endmodule

// ===== logic/eipn_defs.svh
// Constants of the edge-select and nesting interrupt controller.
// Notes on behaviour
// - Edge select pair per input: none/fall/rise/both.
// - Reset clears both edge select registers.
// - Reset loads status word with 02H.
// - Status word full write; enable set/clear.
// - Acknowledgeable needs pending set, mask clear.
// - Needs enable; low waits during high service.
// - Entry latency 7 high, 8 low clocks.
// - Higher level first, then fixed default order.
// - Held request granted once conditions hold.
// - Entry pushes status, PC; sets level flag.
// - Return from interrupt restores PC, status.
// - Software trap unmaskable, vector 003EH/003FH.
// - Status pushed by push, restored by returns/pop.
// - Equal or higher level nests when enabled.
// - High service blocks low; trap always nests.
// - One main instruction runs before pending grant.
// - Pending set by request, cleared on acknowledge.
// - Hold instructions delay grant one instruction.
`ifndef EIPN_DEFS_SVH
`define EIPN_DEFS_SVH
`define EIPN_ADDR_RISE     16'hff48
`define EIPN_ADDR_FALL     16'hff49
`define EIPN_EDGE_RST      7'h00
`define EIPN_PSW_RST       8'h02
`define EIPN_PSW_IE        7
`define EIPN_PSW_ISP       1
`define EIPN_VEC_TRAP      16'h003e
`define EIPN_VEC_BASE      16'h0004
`define EIPN_LAT_MIN_HI    6'd7
`define EIPN_LAT_MIN_LO    6'd8
`define EIPN_ENTRY_FIXED   6'd3
`define EIPN_EXT_N         7
`endif

// ===== logic/eipn_edge_det.sv
// Synchroniser and valid-edge detector for one external request input.
`timescale 1ns/1ps
module eipn_edge_det
    import eipn_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rst_b_i,
    input  wire logic pin_i,
    input  wire logic rise_en_i,
    input  wire logic fall_en_i,
    output logic      event_o
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // The first stage feeds only the second one.
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // With both enables clear no edge is seen, so ports can change use safely.
    always_comb
    begin
        event_o = (rise_en_i & sync_reg & ~prev_reg)
                | (fall_en_i & ~sync_reg & prev_reg);
    end
endmodule

// ===== logic/eipn_pkg.sv
// Types shared by the interrupt controller files.
package eipn_pkg;
    typedef enum logic [4:0] {
        EIPN_IDLE = 5'h01,
        EIPN_WAIT = 5'h02,
        EIPN_PSW  = 5'h04,
        EIPN_PC   = 5'h08,
        EIPN_VEC  = 5'h10
    } eipn_state_t;
endpackage

// ===== testbench/eipn_core_model.sv
// Behavioural core that runs fixed-length instructions and stalls during entry.
`timescale 1ns/1ps
module eipn_core_model
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       svc_busy_i,
    input  wire logic [3:0] len_i,
    input  wire logic [7:0] op_i,
    output logic            instr_end_o,
    output logic            instr_hold_o,
    output logic [7:0]      op_o
);
    logic [3:0] cnt_reg;

    // The count stays at zero while stalled, so no instruction is cut short.
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cnt_reg <= 4'h0;
        else if (svc_busy_i || instr_end_o)
            cnt_reg <= 4'h0;
        else
            cnt_reg <= cnt_reg + 4'h1;
    end

    assign instr_end_o = (cnt_reg == len_i) && !svc_busy_i;
    assign op_o = instr_end_o ? op_i : 8'h00;
    // Every operation but the trap touches the flags and so holds off a grant.
    assign instr_hold_o = |op_o[7:1];
endmodule

// ===== testbench/eipn_ctrl_asserts.sv
// Concurrent checks on the ports of the interrupt controller.
`timescale 1ns/1ps
module eipn_ctrl_asserts
#(
    parameter int SRC_N = 16,
    parameter int IDX_W = $clog2(SRC_N)
)
(
    input wire logic             ref_clk_i,
    input wire logic             rst_b_i,
    input wire logic             instr_end_i,
    input wire logic             instr_hold_i,
    input wire logic             software_trap_i,
    input wire logic [SRC_N-1:0] mask_bit_i,
    input wire logic [SRC_N-1:0] level_select_bit_i,
    input wire logic [15:0]      sfr_addr_i,
    input wire logic [7:0]       sfr_rdata_o,
    input wire logic [7:0]       status_word_o,
    input wire logic [SRC_N-1:0] pending_o,
    input wire logic             ack_o,
    input wire logic [IDX_W-1:0] ack_idx_o,
    input wire logic             svc_busy_o,
    input wire logic             push_status_instruction_o,
    input wire logic             push_pc_o,
    input wire logic             vector_valid_o,
    input wire logic [15:0]      vector_addr_o
);
    logic [SRC_N-1:0] lvl_q;
    logic [SRC_N-1:0] msk_q;
    logic [IDX_W-1:0] idx_q;

    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // Level and mask are snapped so a grant is judged on what the grant edge saw.
    always_ff @(posedge ref_clk_i)
    begin
        lvl_q <= level_select_bit_i;
        msk_q <= mask_bit_i;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (ack_o)
            idx_q <= ack_idx_o;
    end

    chk_mask_grant: assert property (ack_o |-> !msk_q[ack_idx_o])
        else $error("masked source granted");
    chk_ack_enable: assert property (ack_o |-> $past(status_word_o[7]))
        else $error("grant with enable clear");
    chk_low_level: assert property (ack_o && lvl_q[ack_idx_o] |-> $past(status_word_o[1]))
        else $error("low grant in high service");
    chk_hi_latency: assert property (ack_o && !lvl_q[ack_idx_o] |-> ##6 vector_valid_o)
        else $error("high entry time wrong");
    chk_lo_latency: assert property (ack_o && lvl_q[ack_idx_o] |-> ##7 vector_valid_o)
        else $error("low entry time wrong");
    chk_vec_addr: assert property (ack_o |-> ##[6:7]
        (vector_valid_o && vector_addr_o == 16'h0004 + {idx_q, 1'b0}))
        else $error("vector address wrong");
    chk_busy_span: assert property (ack_o |-> svc_busy_o[*7])
        else $error("busy dropped early");
    chk_pend_clear: assert property (ack_o |-> ##2 !pending_o[idx_q])
        else $error("pending kept after grant");
    chk_push_order: assert property (push_status_instruction_o |=> push_pc_o ##1 vector_valid_o)
        else $error("push order wrong");
    chk_enable_off: assert property (vector_valid_o |=> !status_word_o[7])
        else $error("enable not cleared on entry");
    chk_hold_gap: assert property (instr_end_i && instr_hold_i |=> !ack_o)
        else $error("grant after hold instruction");
    chk_trap_vec: assert property (instr_end_i && software_trap_i && !svc_busy_o |->
        ##7 (vector_valid_o && vector_addr_o == 16'h003e))
        else $error("trap entry wrong");
    chk_read_map: assert property
        (!($past(sfr_addr_i) inside {16'hff48, 16'hff49}) |-> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");

    cov_trap: cover property (vector_valid_o && vector_addr_o == 16'h003e);
    cov_low: cover property (ack_o && lvl_q[ack_idx_o]);
    cov_nest: cover property (ack_o && !$past(status_word_o[1]));
endmodule

bind eipn_ctrl eipn_ctrl_asserts #(.SRC_N(SRC_N), .IDX_W(IDX_W)) eipn_ctrl_asserts_i (.*);

// ===== testbench/test_edge_irq_priority_nesting.sv
// Self-checking bench for the edge-select and nesting interrupt controller.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module test_edge_irq_priority_nesting;
    localparam logic [7:0] TRAP = 8'h01, RETURN_FROM_INTERRUPT = 8'h02, RETURN_FROM_TRAP = 8'h04, POP = 8'h08;
    localparam logic [7:0] PUSH = 8'h10, SETE = 8'h20, CLRE = 8'h40, STW = 8'h80;
    logic        ref_clk_i = 1'b0;
    logic        rst_b_i, sfr_wr_i, instr_end_i, instr_hold_i, svc_busy_o, ack_o;
    logic        push_status_instruction_o, push_pc_o, vector_valid_o, software_trap_i;
    logic        return_from_interrupt_i, return_from_trap_i, pop_status_i;
    logic        push_status_i, set_enable_i, clear_enable_i, status_wr_i;
    logic [3:0]  ack_idx_o, len;
    logic [6:0]  external_request_i;
    logic [8:0]  int_req_i;
    logic [7:0]  sfr_wdata_i, status_wdata_i, sfr_rdata_o, status_word_o;
    logic [7:0]  push_data_o, opq, ops;
    logic [15:0] sfr_addr_i, pend_set_i, pend_clr_i, mask_bit_i;
    logic [15:0] level_select_bit_i, pending_o, vector_addr_o;
    int          errors, compares;

    assign {status_wr_i, clear_enable_i, set_enable_i, push_status_i} = ops[7:4];
    assign {pop_status_i, return_from_trap_i, return_from_interrupt_i, software_trap_i} = ops[3:0];

    always #12.5 ref_clk_i = ~ref_clk_i;

    eipn_ctrl eipn_ctrl_i (.*);
    eipn_core_model eipn_core_model_i
    (
        .ref_clk_i    (ref_clk_i),
        .rst_b_i      (rst_b_i),
        .svc_busy_i   (svc_busy_o),
        .len_i        (len),
        .op_i         (opq),
        .instr_end_o  (instr_end_i),
        .instr_hold_o (instr_hold_i),
        .op_o         (ops)
    );

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        tick(1);
        sfr_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        sfr_addr_i = a;
        tick(2);
        `CHK(sfr_rdata_o, e);
    endtask

    task automatic sw(input logic [7:0] e);
        tick(2);
        `CHK(status_word_o, e);
    endtask

    task automatic pset(input logic [15:0] v);
        pend_set_i = v;
        tick(1);
        pend_set_i = 16'h0000;
    endtask

    task automatic clr();
        pend_clr_i = 16'hffff;
        tick(1);
        pend_clr_i = 16'h0000;
    endtask

    // The operation rides on the next boundary the core reaches.
    task automatic op(input logic [7:0] o, input logic [7:0] w);
        opq = o;
        status_wdata_i = w;
        repeat (60) if (!instr_end_i) tick(1);
        tick(1);
        opq = 8'h00;
    endtask

    task automatic ent(input logic [3:0] i, input logic [15:0] va, input int lat,
                       input logic [7:0] pd);
        int n;
        repeat (80) if (!svc_busy_o) tick(1);
        if (ack_o)
            `CHK(ack_idx_o, i);
        for (n = 1; n < 12 && !vector_valid_o; n++)
        begin
            if (push_status_instruction_o)
                `CHK(push_data_o, pd);
            tick(1);
        end
        `CHK(n, lat);
        `CHK(vector_addr_o, va);
    endtask

    task automatic t_regs();
        rd(16'hff48, 8'h00);
        rd(16'hff49, 8'h00);
        `CHK(status_word_o, 8'h02);
        wr(16'hff48, 8'hff);
        rd(16'hff48, 8'h7f);
        wr(16'hff49, 8'h81);
        rd(16'hff49, 8'h01);
        rd(16'hff4a, 8'h00);
    endtask

    task automatic t_edges();
        logic [2:0] p;
        for (int m = 0; m < 4; m++)
        begin
            p = 3'(2 * m);
            wr(16'hff48, 8'(m[1]) << p);
            wr(16'hff49, 8'(m[0]) << p);
            external_request_i[p] = 1'b1;
            tick(5);
            `CHK(pending_o[p], m[1]);
            clr();
            external_request_i[p] = 1'b0;
            tick(5);
            `CHK(pending_o[p], m[0]);
            clr();
        end
        wr(16'hff48, 8'h00);
        wr(16'hff49, 8'h00);
    endtask

    task automatic t_nest();
        mask_bit_i = 16'hff97;
        pset(16'h0028);
        op(SETE, 8'h00);
        `CHK(svc_busy_o, 1'b0);
        ent(4'h3, 16'h000a, 7, 8'h82);
        sw(8'h00);
        op(SETE, 8'h00);
        ent(4'h5, 16'h000e, 7, 8'h80);
        level_select_bit_i = 16'h0004;
        mask_bit_i = 16'hff93;
        pset(16'h0004);
        op(SETE, 8'h00);
        tick(16);
        `CHK(pending_o[2], 1'b1);
        `CHK(svc_busy_o, 1'b0);
        op(RETURN_FROM_INTERRUPT, 8'h82);
        `CHK(svc_busy_o, 1'b0);
        ent(4'h2, 16'h0008, 8, 8'h82);
    endtask

    task automatic t_level();
        level_select_bit_i = 16'h0002;
        mask_bit_i = 16'hffbd;
        pset(16'h0042);
        op(STW, 8'h82);
        ent(4'h6, 16'h0010, 7, 8'h82);
        op(RETURN_FROM_INTERRUPT, 8'h82);
        ent(4'h1, 16'h0006, 8, 8'h82);
    endtask

    task automatic t_mask();
        mask_bit_i = 16'hffff;
        level_select_bit_i = 16'h0000;
        int_req_i = 9'h002;
        tick(1);
        int_req_i = 9'h000;
        op(STW, 8'h82);
        tick(16);
        `CHK(pending_o[8], 1'b1);
        `CHK(svc_busy_o, 1'b0);
        mask_bit_i = 16'hfeff;
        ent(4'h8, 16'h0014, 7, 8'h82);
    endtask

    // A slow core here shows the trap does not lean on instruction length.
    task automatic t_trap();
        len = 4'h9;
        op(TRAP, 8'h00);
        ent(4'h0, 16'h003e, 7, 8'h00);
        op(RETURN_FROM_TRAP, 8'h82);
        sw(8'h82);
        len = 4'h3;
        op(STW, 8'h3c);
        sw(8'h3c);
        op(SETE, 8'h00);
        sw(8'hbc);
        op(PUSH, 8'h00);
        tick(1);
        `CHK(push_data_o, 8'hbc);
        op(CLRE, 8'h00);
        sw(8'h3c);
        op(POP, 8'h02);
        sw(8'h02);
    endtask

    task automatic end_sim();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        rst_b_i = 1'b0;
        sfr_wr_i = 1'b0;
        sfr_addr_i = 16'h0000;
        sfr_wdata_i = 8'h00;
        external_request_i = 7'h00;
        int_req_i = 9'h000;
        pend_set_i = 16'h0000;
        pend_clr_i = 16'h0000;
        mask_bit_i = 16'hffff;
        level_select_bit_i = 16'h0000;
        status_wdata_i = 8'h00;
        opq = 8'h00;
        len = 4'h3;
        errors = 0;
        compares = 0;
        tick(20);
        rst_b_i = 1'b1;
        tick(4);
        t_regs();
        t_edges();
        t_nest();
        t_level();
        t_mask();
        t_trap();
        end_sim();
    end

    initial
    begin
        #400us;
        errors++;
        end_sim();
    end
endmodule
